/* core/hrl_pkg.sv */
// Purpose: Shared constants and types for the hub reset and link power control
// Assumes: 100 MHz core clock
// Notes: Latency counts are derived from the printed times
package hrl_pkg;

    // ----------------------------------------
    // Clock and timer widths
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TMR_W = 19;
    localparam int POR_W = 16;

    // ----------------------------------------
    // Link latency times, as printed
    // ----------------------------------------
    localparam int L2_ENTRY_TIME_MS = 3;
    localparam int L2_EXIT_TIME_MS = 2;
    localparam int L1_ENTRY_TIME_US = 10;
    localparam int L1_EXIT_TIME_US = 50;

    // Approximate times keep the figure; strict bounds drop two, as the state step adds a cycle
    localparam logic [TMR_W-1:0] L2_ENTRY_CYCLES = TMR_W'(L2_ENTRY_TIME_MS * 1000000 / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] L2_EXIT_CYCLES = TMR_W'(L2_EXIT_TIME_MS * 1000000 / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] L1_ENTRY_CYCLES = TMR_W'(L1_ENTRY_TIME_US * 1000 / CLK_PERIOD_NS - 2);
    localparam logic [TMR_W-1:0] L1_EXIT_CYCLES = TMR_W'(L1_EXIT_TIME_US * 1000 / CLK_PERIOD_NS - 2);

    // Power-on hold, no figure given; plain default
    localparam logic [POR_W-1:0] POR_CYCLES = 16'h03e8;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [6:0] ADDR_DEFAULT = 7'h00;
    localparam logic [7:0] CONFIG_UNCONFIGURED = 8'h00;

    // ----------------------------------------
    // Link power states
    // ----------------------------------------
    typedef enum logic [6:0] {
        LINK_L0       = 7'h01,
        LINK_L1_ENTER = 7'h02,
        LINK_L1       = 7'h04,
        LINK_L1_EXIT  = 7'h08,
        LINK_L2_ENTER = 7'h10,
        LINK_L2       = 7'h20,
        LINK_L2_EXIT  = 7'h40
    } hrl_link_t;

    function automatic logic is_suspend_side(input hrl_link_t s);
        return (s == LINK_L2_ENTER) || (s == LINK_L2) || (s == LINK_L2_EXIT);
    endfunction

endpackage

/* core/hrl_lat_timer.sv */
// Purpose: Down counter timing one link state latency
// Assumes: A load of zero idles the counter with no expiry
// Notes: Expiry is a one-cycle pulse from a flop
`timescale 1ns/1ps
module hrl_lat_timer (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Control
    input wire logic i_load,
    input wire logic [hrl_pkg::TMR_W-1:0] i_value,
    // Status
    output logic o_expired
);

    typedef struct packed {
        logic [hrl_pkg::TMR_W-1:0] cnt;
        logic expired;
    } hrl_tmr_state_t;

    hrl_tmr_state_t s;
    hrl_tmr_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.expired = 1'b0;
        if (i_load) begin
            next_s.cnt = i_value;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - 1'b1;
            next_s.expired = (s.cnt == hrl_pkg::TMR_W'(1));
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_expired = s.expired;

endmodule

/* core/hrl_reset_link_ctrl.sv */
// Purpose: Chip reset combining and link power state control of a hub
// Assumes: All inputs synchronous to i_clock; i_arst_n is the power-on reset
// Notes: Notes on behaviour
// Notes on behaviour
// (R1) Power-on, the external reset pin and an upstream bus reset are all recognised as reset sources.
// (R2) After power comes up a timer holds the internal reset for the power-on period, then releases it.
// (R3) While the external reset pin is low the device sits in low-current standby.
// (R4) External reset disables the PHY and floats all differential pairs.
// (R5) External reset aborts every transaction at once and keeps no earlier state.
// (R6) External reset returns every internal register to its default; the code keeps the power-on count por_cnt as it was.
// (R7) External reset stops the crystal oscillator and the PLL for as long as it is held.
// (R8) An upstream bus reset sets the device address to zero.
// (R9) An upstream bus reset leaves the device unconfigured until the host configures it again.
// (R10) A bus reset that arrives while suspended brings the link back to the on state.
// (R11) A reset from upstream is never passed to downstream devices.
// (R12) The link has three power states: on, sleep and suspend.
// (R13) Suspend is entered in about 3 ms and left about 2 ms after resume signalling begins.
// (R14) Sleep is entered in under 10 us and left in under 50 us.
// (R15) Sleep and suspend are only reached from the on state, never from each other.
`timescale 1ns/1ps
module hrl_reset_link_ctrl #(
    parameter logic [hrl_pkg::TMR_W-1:0] L2_ENTRY_CYCLES = hrl_pkg::L2_ENTRY_CYCLES,
    parameter logic [hrl_pkg::TMR_W-1:0] L2_EXIT_CYCLES = hrl_pkg::L2_EXIT_CYCLES,
    parameter logic [hrl_pkg::TMR_W-1:0] L1_EXIT_CYCLES = hrl_pkg::L1_EXIT_CYCLES
) (
    // Clock and power-on reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Reset sources
    input wire logic i_ext_reset_n,
    input wire logic i_bus_reset,
    // Host requests
    input wire logic i_set_address,
    input wire logic [6:0] i_address,
    input wire logic i_set_config,
    input wire logic [7:0] i_config,
    input wire logic i_sleep_req,
    input wire logic i_wake_req,
    input wire logic i_suspend_req,
    input wire logic i_resume,
    // Chip controls
    output logic o_int_reset,
    output logic o_standby,
    output logic o_phy_enable,
    output logic o_diff_hiz,
    output logic o_xtal_enable,
    output logic o_pll_enable,
    output logic o_abort,
    output logic o_downstream_reset,
    // Device state
    output logic [6:0] o_address,
    output logic [7:0] o_config,
    output logic o_configured,
    output hrl_pkg::hrl_link_t o_link_state
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [hrl_pkg::POR_W-1:0] por_cnt;
        logic int_reset;
        logic standby;
        logic phy_en;
        logic hiz;
        logic xtal_en;
        logic pll_en;
        logic abort;
        logic dn_reset;
        logic [6:0] address;
        logic [7:0] config_val;
        logic configured;
        hrl_pkg::hrl_link_t link;
    } hrl_ctrl_state_t;

    hrl_ctrl_state_t s;
    hrl_ctrl_state_t next_s;
    logic tmr_load;
    logic [hrl_pkg::TMR_W-1:0] tmr_value;
    logic tmr_expired;

    hrl_lat_timer u_timer (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .o_expired(tmr_expired)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        tmr_load = 1'b0;
        tmr_value = '0;
        next_s.dn_reset = 1'b0; // R11
        next_s.abort = 1'b0;
        if (!i_ext_reset_n) begin
            // Pin reset wipes everything except the power-on count, which keeps its value even if unfinished
            next_s.int_reset = 1'b1; // R1
            next_s.standby = 1'b1; // R3
            next_s.phy_en = 1'b0; // R4
            next_s.hiz = 1'b1; // R4
            next_s.abort = 1'b1; // R5
            next_s.xtal_en = 1'b0; // R7
            next_s.pll_en = 1'b0; // R7
            next_s.address = hrl_pkg::ADDR_DEFAULT; // R6
            next_s.config_val = hrl_pkg::CONFIG_UNCONFIGURED; // R6
            next_s.configured = 1'b0; // R6
            next_s.link = hrl_pkg::LINK_L0; // R6
            // Latency count is state too; clear it so no stale expiry survives
            tmr_load = 1'b1; // R6
            tmr_value = '0; // R5
        end else if (s.por_cnt != hrl_pkg::POR_CYCLES) begin
            // Clocks run while the power-on timer holds reset
            next_s.por_cnt = s.por_cnt + 1'b1; // R2
            next_s.int_reset = 1'b1; // R2
            next_s.standby = 1'b0;
            next_s.xtal_en = 1'b1;
            next_s.pll_en = 1'b1;
        end else begin
            next_s.int_reset = 1'b0;
            next_s.standby = 1'b0;
            next_s.xtal_en = 1'b1;
            next_s.pll_en = 1'b1;
            next_s.phy_en = 1'b1;
            next_s.hiz = 1'b0;
            if (i_bus_reset) begin
                next_s.address = hrl_pkg::ADDR_DEFAULT; // R8
                next_s.config_val = hrl_pkg::CONFIG_UNCONFIGURED; // R9
                next_s.configured = 1'b0; // R9
                if (hrl_pkg::is_suspend_side(s.link)) begin
                    next_s.link = hrl_pkg::LINK_L0; // R10
                    tmr_load = 1'b1;
                    tmr_value = '0;
                end
            end else begin
                if (i_set_address) begin
                    next_s.address = i_address;
                end
                if (i_set_config) begin
                    next_s.config_val = i_config;
                    next_s.configured = (i_config != hrl_pkg::CONFIG_UNCONFIGURED);
                end
            end
            if (!(i_bus_reset && hrl_pkg::is_suspend_side(s.link))) begin
                case (s.link)
                    hrl_pkg::LINK_L0: begin
                        // Sleep wins when both low-power requests arrive together
                        if (i_sleep_req) begin
                            tmr_load = 1'b1;
                            tmr_value = hrl_pkg::L1_ENTRY_CYCLES; // R14
                            next_s.link = hrl_pkg::LINK_L1_ENTER; // R12
                        end else if (i_suspend_req) begin
                            tmr_load = 1'b1;
                            tmr_value = L2_ENTRY_CYCLES; // R13
                            next_s.link = hrl_pkg::LINK_L2_ENTER; // R12
                        end
                    end
                    hrl_pkg::LINK_L1_ENTER: begin
                        if (tmr_expired) begin
                            next_s.link = hrl_pkg::LINK_L1;
                        end
                    end
                    hrl_pkg::LINK_L1: begin
                        // Only a wake leaves sleep; suspend must go via the on state
                        if (i_wake_req) begin
                            tmr_load = 1'b1;
                            tmr_value = L1_EXIT_CYCLES; // R14
                            next_s.link = hrl_pkg::LINK_L1_EXIT; // R15
                        end
                    end
                    hrl_pkg::LINK_L1_EXIT: begin
                        if (tmr_expired) begin
                            next_s.link = hrl_pkg::LINK_L0;
                        end
                    end
                    hrl_pkg::LINK_L2_ENTER: begin
                        if (tmr_expired) begin
                            next_s.link = hrl_pkg::LINK_L2;
                        end
                    end
                    hrl_pkg::LINK_L2: begin
                        if (i_resume) begin
                            tmr_load = 1'b1;
                            tmr_value = L2_EXIT_CYCLES; // R13
                            next_s.link = hrl_pkg::LINK_L2_EXIT; // R15
                        end
                    end
                    hrl_pkg::LINK_L2_EXIT: begin
                        if (tmr_expired) begin
                            next_s.link = hrl_pkg::LINK_L0;
                        end
                    end
                    default: begin
                        next_s.link = hrl_pkg::LINK_L0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '{por_cnt: '0, int_reset: 1'b1, standby: 1'b0, phy_en: 1'b0, hiz: 1'b1,
                   xtal_en: 1'b1, pll_en: 1'b1, abort: 1'b1, dn_reset: 1'b0,
                   address: hrl_pkg::ADDR_DEFAULT, config_val: hrl_pkg::CONFIG_UNCONFIGURED,
                   configured: 1'b0, link: hrl_pkg::LINK_L0};
        end else begin
            s <= next_s;
        end
    end

    assign o_int_reset = s.int_reset;
    assign o_standby = s.standby;
    assign o_phy_enable = s.phy_en;
    assign o_diff_hiz = s.hiz;
    assign o_xtal_enable = s.xtal_en;
    assign o_pll_enable = s.pll_en;
    assign o_abort = s.abort;
    assign o_downstream_reset = s.dn_reset;
    assign o_address = s.address;
    assign o_config = s.config_val;
    assign o_configured = s.configured;
    assign o_link_state = s.link;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    a_ext_reset_int: assert property (!i_ext_reset_n |=> o_int_reset && o_standby) // R1
        else $error("internal reset or standby missing under pin reset");
    a_por_hold: assert property (i_ext_reset_n && s.por_cnt != hrl_pkg::POR_CYCLES |=> o_int_reset) // R2
        else $error("power-on hold released early");
    a_standby_held: assert property (!i_ext_reset_n [*2] |=> o_standby) // R3
        else $error("standby dropped while pin reset held");
    a_phy_off: assert property (!i_ext_reset_n |=> !o_phy_enable && o_diff_hiz) // R4
        else $error("phy active under pin reset");
    a_abort_now: assert property (!i_ext_reset_n |=> o_abort) // R5
        else $error("transactions not aborted");
    a_regs_default: assert property (!i_ext_reset_n |=>
        o_address == '0 && !o_configured && o_link_state == hrl_pkg::LINK_L0) // R6
        else $error("registers not at default after pin reset");
    a_clocks_stop: assert property (!i_ext_reset_n |=> !o_xtal_enable && !o_pll_enable) // R7
        else $error("oscillator or pll running under pin reset");
    a_bus_addr: assert property (i_ext_reset_n && !s.int_reset && i_bus_reset |=> o_address == '0) // R8
        else $error("address not cleared by bus reset");
    a_bus_unconf: assert property (i_ext_reset_n && !s.int_reset && i_bus_reset |=> !o_configured) // R9
        else $error("still configured after bus reset");
    a_bus_wake: assert property (i_ext_reset_n && !s.int_reset && i_bus_reset &&
        s.link == hrl_pkg::LINK_L2 |=> o_link_state == hrl_pkg::LINK_L0) // R10
        else $error("suspend not left on bus reset");
    a_no_forward: assert property (i_bus_reset |=> !o_downstream_reset) // R11
        else $error("reset forwarded downstream");
    a_link_onehot: assert property ($onehot(o_link_state)) // R12
        else $error("link state not one-hot");
    a_l2_entry: assert property (s.link == hrl_pkg::LINK_L0 && next_s.link == hrl_pkg::LINK_L2_ENTER
        |-> tmr_load && tmr_value == L2_ENTRY_CYCLES) // R13
        else $error("suspend entry timer wrong");
    a_l1_entry: assert property (s.link == hrl_pkg::LINK_L0 && next_s.link == hrl_pkg::LINK_L1_ENTER
        |-> tmr_load && tmr_value == hrl_pkg::L1_ENTRY_CYCLES) // R14
        else $error("sleep entry timer wrong");
    a_no_lp_hop: assert property (s.link == hrl_pkg::LINK_L1 |=>
        !hrl_pkg::is_suspend_side(s.link)) // R15
        else $error("sleep jumped to suspend");

    c_sleep_round: cover property (s.link == hrl_pkg::LINK_L1_EXIT ##1 s.link == hrl_pkg::LINK_L0);
    c_suspend_in: cover property (s.link == hrl_pkg::LINK_L2_ENTER ##1 s.link == hrl_pkg::LINK_L2);
    c_bus_wake: cover property (s.link == hrl_pkg::LINK_L2 && i_bus_reset && !s.int_reset);
    c_pin_reset: cover property (!i_ext_reset_n ##1 i_ext_reset_n);

endmodule

/* sim/hrl_host_model.sv */
// Purpose: Upstream host and board reset source facing the hub reset block
// Assumes: Requests change just after a rising edge of i_clock
// Notes: Requests last one cycle; the reset pin is a level
`timescale 1ns/1ps
module hrl_host_model (
    // Clock
    input wire logic i_clock,
    // Reset sources
    output logic o_ext_reset_n,
    output logic o_bus_reset,
    // Host requests
    output logic o_set_address,
    output logic [6:0] o_address,
    output logic o_set_config,
    output logic [7:0] o_config,
    output logic o_sleep_req,
    output logic o_wake_req,
    output logic o_suspend_req,
    output logic o_resume
);
    // ----------------------------------------
    // Request lines, one-hot so two never collide
    // ----------------------------------------
    logic [6:0] req;
    assign {o_resume, o_suspend_req, o_wake_req, o_sleep_req, o_set_config, o_set_address, o_bus_reset} = req;
    initial begin
        o_ext_reset_n = 1'b1;
        req = 7'h00;
        o_address = 7'h00;
        o_config = 8'h00;
    end
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    // Data inverts once unqualified, so a stale value never passes
    task automatic send(input int kind, input logic [7:0] val);
        @(posedge i_clock);
        req <= 7'h01 << kind;
        o_address <= val[6:0];
        o_config <= val;
        @(posedge i_clock);
        req <= 7'h00;
        o_address <= ~val[6:0];
        o_config <= ~val;
    endtask
    task automatic pin(input logic level);
        @(posedge i_clock);
        o_ext_reset_n <= level;
    endtask
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for the hub reset and link power block
// Assumes: Host model drives every request input
// Notes: Long link latencies shortened by parameter
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Settings and nets
    // ----------------------------------------
    localparam int L2E = 20;
    localparam int L2X = 15;
    localparam int L1X = 10;
    localparam int K_BUS = 0, K_ADDR = 1, K_CFG = 2, K_SLEEP = 3, K_WAKE = 4, K_SUSP = 5, K_RES = 6;
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic ext_n, bus_rst, set_addr, set_cfg, sleep_req, wake_req, susp_req, resume;
    logic [6:0] addr_in;
    logic [7:0] cfg_in;
    logic int_rst, standby, phy_en, diff_hiz, xtal_en, pll_en, abort, ds_rst, configured;
    logic [6:0] addr_q;
    logic [7:0] cfg_q;
    hrl_pkg::hrl_link_t link;
    int num_errors = 0;
    int checks_done = 0;
    always #5 i_clock = ~i_clock;

    hrl_host_model hrl_host_model_i (.i_clock(i_clock), .o_ext_reset_n(ext_n), .o_bus_reset(bus_rst),
        .o_set_address(set_addr), .o_address(addr_in), .o_set_config(set_cfg), .o_config(cfg_in),
        .o_sleep_req(sleep_req), .o_wake_req(wake_req), .o_suspend_req(susp_req), .o_resume(resume));
    hrl_reset_link_ctrl #(.L2_ENTRY_CYCLES(19'(L2E)), .L2_EXIT_CYCLES(19'(L2X)), .L1_EXIT_CYCLES(19'(L1X)))
    hrl_reset_link_ctrl_i (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_ext_reset_n(ext_n), .i_bus_reset(bus_rst),
        .i_set_address(set_addr), .i_address(addr_in), .i_set_config(set_cfg), .i_config(cfg_in),
        .i_sleep_req(sleep_req), .i_wake_req(wake_req), .i_suspend_req(susp_req), .i_resume(resume),
        .o_int_reset(int_rst), .o_standby(standby), .o_phy_enable(phy_en), .o_diff_hiz(diff_hiz),
        .o_xtal_enable(xtal_en), .o_pll_enable(pll_en), .o_abort(abort), .o_downstream_reset(ds_rst),
        .o_address(addr_q), .o_config(cfg_q), .o_configured(configured), .o_link_state(link));

    // ----------------------------------------
    // Compare, wait and report
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Counts edges until the link reaches a state; overrun ends the run
    task automatic wait_lnk(input hrl_pkg::hrl_link_t want, input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (link !== want && n <= hi) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check_rng("link_cycles", lo, hi, n);
        if (link !== want) end_of_test();
    endtask
    task automatic wait_rst(input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (int_rst !== 1'b0 && n <= hi) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check_rng("reset_cycles", lo, hi, n);
        if (int_rst !== 1'b0) end_of_test();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_por();
        #1;
        check("int_reset", 1, int_rst);
        check("hiz", 1, diff_hiz);
        check("link", hrl_pkg::LINK_L0, link);
        @(posedge i_clock);
        i_arst_n <= 1'b1;
        wait_rst(hrl_pkg::POR_CYCLES, hrl_pkg::POR_CYCLES + 3);
        check("phy", 1, phy_en);
        check("hiz", 0, diff_hiz);
        check("abort", 0, abort);
    endtask
    task automatic t_bus();
        hrl_host_model_i.send(K_ADDR, 8'h35);
        hrl_host_model_i.send(K_CFG, 8'h02);
        #1;
        check("addr", 7'h35, addr_q);
        check("config", 8'h02, cfg_q);
        check("configured", 1, configured);
        hrl_host_model_i.send(K_BUS, 8'h00);
        #1;
        check("addr", 7'h00, addr_q);
        check("config", 8'h00, cfg_q);
        check("configured", 0, configured);
        check("downstream", 0, ds_rst);
    endtask
    // Sleep round trip; suspend refused while asleep
    task automatic t_sleep();
        hrl_host_model_i.send(K_SLEEP, 8'h00);
        wait_lnk(hrl_pkg::LINK_L1, 900, hrl_pkg::L1_ENTRY_TIME_US * 1000 / hrl_pkg::CLK_PERIOD_NS - 1);
        hrl_host_model_i.send(K_SUSP, 8'h00);
        repeat (3) @(posedge i_clock);
        #1;
        check("link", hrl_pkg::LINK_L1, link);
        hrl_host_model_i.send(K_WAKE, 8'h00);
        wait_lnk(hrl_pkg::LINK_L0, L1X, L1X + 3);
    endtask
    task automatic t_suspend();
        hrl_host_model_i.send(K_SUSP, 8'h00);
        wait_lnk(hrl_pkg::LINK_L2, L2E, L2E + 3);
        hrl_host_model_i.send(K_SLEEP, 8'h00);
        #1;
        check("link", hrl_pkg::LINK_L2, link);
        hrl_host_model_i.send(K_RES, 8'h00);
        wait_lnk(hrl_pkg::LINK_L0, L2X, L2X + 3);
        hrl_host_model_i.send(K_SUSP, 8'h00);
        wait_lnk(hrl_pkg::LINK_L2, L2E, L2E + 3);
        hrl_host_model_i.send(K_BUS, 8'h00);
        #1;
        check("link", hrl_pkg::LINK_L0, link);
    endtask
    // Pin reset in mid-transition, held, then released
    task automatic t_ext();
        hrl_host_model_i.send(K_ADDR, 8'h7f);
        hrl_host_model_i.send(K_SLEEP, 8'h00);
        hrl_host_model_i.pin(1'b0);
        @(posedge i_clock);
        #1;
        check("int_reset", 1, int_rst);
        check("standby", 1, standby);
        check("phy", 0, phy_en);
        check("hiz", 1, diff_hiz);
        check("abort", 1, abort);
        check("addr", 7'h00, addr_q);
        check("link", hrl_pkg::LINK_L0, link);
        repeat (20) @(posedge i_clock);
        #1;
        check("xtal", 0, xtal_en);
        check("pll", 0, pll_en);
        hrl_host_model_i.pin(1'b1);
        wait_rst(1, 3);
        check("standby", 0, standby);
        check("xtal", 1, xtal_en);
        check("pll", 1, pll_en);
    endtask

    initial begin
        repeat (4) @(posedge i_clock);
        t_por();
        t_bus();
        t_sleep();
        t_suspend();
        t_ext();
        end_of_test();
    end
endmodule
